// ---- src/spd_smbus_master.sv ----
// spd eeprom smbus master with hub control and status registers
//
// Contract
// - write request: opcode, slave address, data, byte address
// - write command issues one smbus byte write
// - successful write sets status bit 14
// - read: address write, repeated start, one byte
// - read frame is the 39-bit sequence
// - smbus clock is serial clock divided by 16
// - nack or stretch timeout abandons, sets bit 14
// - timeout no shorter than 25 ms
// - timeout counts only while awaiting slave response
// - reset returns configuration registers to defaults
// - interface cells power down until init command
// - reset disables all channel clock generators
// - control bits shut off empty stick channels
// - read data valid bit 15, cleared on read
`timescale 1ns/100ps
`default_nettype none
module spd_smbus_master #(
    parameter int TIMEOUT_CYC = spd_pkg::TIMEOUT_CYC
) (
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    input  wire logic        expansion_serial_clock_i,
    input  wire logic        spd_cmd_valid_i,
    input  wire logic        spd_cmd_write_i,
    input  wire logic [7:0]  slave_address_field_i,
    input  wire logic [15:0] data_field_i,
    output logic             spd_cmd_ready_o,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    output logic [15:0]      reg_rdata_o,
    input  wire logic        exp_cell_init_i,
    input  wire logic        stick_cell_init_i,
    output logic             exp_cell_pd_o,
    output logic [1:0]       stick_cell_pd_o,
    output logic [1:0]       clock_generator_en_o,
    input  wire logic        smbus_clock_pin_i,
    output logic             smbus_clock_pin_o,
    output logic             smbus_clock_pin_oe_n_o,
    input  wire logic        smbus_data_pin_i,
    output logic             smbus_data_pin_o,
    output logic             smbus_data_pin_oe_n_o
);
    localparam int TO_W = $clog2(TIMEOUT_CYC + 1);
    localparam logic [TO_W-1:0] TO_LIM = TO_W'(TIMEOUT_CYC);
    localparam logic [3:0] PH_END = 4'(spd_pkg::PH_LAST);
    localparam logic [3:0] PH_MID = 4'(spd_pkg::PH_SAMPLE);

    // ------------------------------------------------------------
    // serial clock edge detect
    // ------------------------------------------------------------
    logic sck_q;
    logic next_sck_q;
    logic tick;

    always_comb begin
        next_sck_q = expansion_serial_clock_i;
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sck_q <= 1'b0;
        end else begin
            sck_q <= next_sck_q;
        end
    end

    assign tick = expansion_serial_clock_i && !sck_q;

    // ------------------------------------------------------------
    // smbus sequencer
    // ------------------------------------------------------------
    spd_pkg::spd_state_e state;
    spd_pkg::spd_state_e next_state;
    logic [3:0]      ph;
    logic [3:0]      next_ph;
    logic [2:0]      bc;
    logic [2:0]      next_bc;
    logic [1:0]      idx;
    logic [1:0]      next_idx;
    logic [7:0]      sh;
    logic [7:0]      next_sh;
    logic            wr;
    logic            next_wr;
    logic            rep;
    logic            next_rep;
    logic            ack_ok;
    logic            next_ack_ok;
    logic [7:0]      sa;
    logic [7:0]      next_sa;
    logic [15:0]     dat;
    logic [15:0]     next_dat;
    logic [TO_W-1:0] to_cnt;
    logic [TO_W-1:0] next_to_cnt;
    logic            scl_rel;
    logic            next_scl_rel;
    logic            sda_rel;
    logic            next_sda_rel;
    logic            fin_ok;
    logic            fin_err;
    logic            accept;
    logic            stretch;
    logic            step;
    logic            at_end;
    logic            at_mid;
    logic            rd_byte;
    logic            waiting;
    logic [1:0]      q;

    assign q       = ph[3:2];
    assign rd_byte = (idx == 2'h3);
    assign stretch = (state != spd_pkg::SPD_IDLE) && scl_rel
                     && !smbus_clock_pin_i;
    assign step    = tick && !stretch;
    assign at_end  = step && (ph == PH_END);
    assign at_mid  = step && (ph == PH_MID);
    assign accept  = spd_cmd_valid_i && (state == spd_pkg::SPD_IDLE);
    // awaiting the slave: its ack slot, or a held clock
    assign waiting = stretch
                     || (state == spd_pkg::SPD_ACK && !rd_byte);

    always_comb begin
        next_state  = state;
        next_ph     = ph;
        next_bc     = bc;
        next_idx    = idx;
        next_sh     = sh;
        next_wr     = wr;
        next_rep    = rep;
        next_ack_ok = ack_ok;
        next_sa     = sa;
        next_dat    = dat;
        next_to_cnt = waiting ? to_cnt + 1'b1 : '0;
        fin_ok      = 1'b0;
        fin_err     = 1'b0;
        if (step && state != spd_pkg::SPD_IDLE) begin
            next_ph = ph + 4'h1;
        end
        case (state)
            spd_pkg::SPD_IDLE: begin
                if (accept) begin
                    next_state = spd_pkg::SPD_START;
                    next_ph    = '0;
                    next_idx   = '0;
                    next_rep   = 1'b0;
                    next_wr    = spd_cmd_write_i;
                    next_sa    = slave_address_field_i;
                    next_dat   = data_field_i;
                    next_sh    = {slave_address_field_i[7:1], 1'b0};
                end
            end
            spd_pkg::SPD_START: begin
                if (at_end) begin
                    next_state = spd_pkg::SPD_BYTE;
                    next_bc    = '0;
                end
            end
            spd_pkg::SPD_BYTE: begin
                if (at_mid && rd_byte) begin
                    next_sh = {sh[6:0], smbus_data_pin_i};
                end
                if (at_end) begin
                    if (!rd_byte) begin
                        next_sh = {sh[6:0], 1'b0};
                    end
                    next_bc = bc + 3'h1;
                    if (bc == 3'h7) begin
                        next_state = spd_pkg::SPD_ACK;
                    end
                end
            end
            spd_pkg::SPD_ACK: begin
                if (at_mid) begin
                    next_ack_ok = !smbus_data_pin_i;
                end
                if (at_end) begin
                    next_bc = '0;
                    if (rd_byte) begin
                        next_state = spd_pkg::SPD_STOP;
                    end else if (!ack_ok) begin
                        next_state = spd_pkg::SPD_STOP;
                        next_wr    = 1'b0;
                        next_idx   = '0;
                        next_rep   = 1'b1;
                    end else begin
                        case (idx)
                            2'h0: begin
                                next_idx   = 2'h1;
                                next_sh    = dat[7:0];
                                next_state = spd_pkg::SPD_BYTE;
                            end
                            2'h1: begin
                                next_idx = 2'h2;
                                if (wr) begin
                                    next_sh    = dat[15:8];
                                    next_state = spd_pkg::SPD_BYTE;
                                end else begin
                                    next_sh    = {sa[7:1], 1'b1};
                                    next_rep   = 1'b1;
                                    next_state = spd_pkg::SPD_START;
                                end
                            end
                            2'h2: begin
                                if (wr) begin
                                    next_state = spd_pkg::SPD_STOP;
                                end else begin
                                    next_idx   = 2'h3;
                                    next_state = spd_pkg::SPD_BYTE;
                                end
                            end
                            default: begin
                                next_state = spd_pkg::SPD_STOP;
                            end
                        endcase
                    end
                end
            end
            spd_pkg::SPD_STOP: begin
                if (at_end) begin
                    next_state = spd_pkg::SPD_IDLE;
                    next_ph    = '0;
                    // rep with idx 0 here marks a slave nack
                    fin_err    = rep && (idx == 2'h0);
                    fin_ok     = !fin_err;
                end
            end
            default: begin
                next_state = spd_pkg::SPD_IDLE;
            end
        endcase
        if (state != spd_pkg::SPD_IDLE && to_cnt >= TO_LIM) begin
            next_state  = spd_pkg::SPD_IDLE;
            next_ph     = '0;
            next_to_cnt = '0;
            fin_err     = 1'b1;
            fin_ok      = 1'b0;
        end
    end

    // line levels: release unless a quarter asks for low
    always_comb begin
        next_scl_rel = 1'b1;
        next_sda_rel = 1'b1;
        case (state)
            spd_pkg::SPD_START: begin
                next_scl_rel = !(q == 2'h3 || (rep && q == 2'h0));
                next_sda_rel = (q < 2'h2);
            end
            spd_pkg::SPD_BYTE: begin
                next_scl_rel = (q == 2'h1 || q == 2'h2);
                next_sda_rel = rd_byte || sh[7];
            end
            spd_pkg::SPD_ACK: begin
                // slave ack slot, or master nack after read data
                next_scl_rel = (q == 2'h1 || q == 2'h2);
                next_sda_rel = 1'b1;
            end
            spd_pkg::SPD_STOP: begin
                next_scl_rel = (q != 2'h0);
                next_sda_rel = (q > 2'h1);
            end
            default: begin
                next_scl_rel = 1'b1;
                next_sda_rel = 1'b1;
            end
        endcase
        if (next_state == spd_pkg::SPD_IDLE) begin
            next_scl_rel = 1'b1;
            next_sda_rel = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state   <= spd_pkg::SPD_IDLE;
            ph      <= '0;
            bc      <= '0;
            idx     <= '0;
            sh      <= '0;
            wr      <= 1'b0;
            rep     <= 1'b0;
            ack_ok  <= 1'b0;
            sa      <= '0;
            dat     <= '0;
            to_cnt  <= '0;
            scl_rel <= 1'b1;
            sda_rel <= 1'b1;
        end else begin
            state   <= next_state;
            ph      <= next_ph;
            bc      <= next_bc;
            idx     <= next_idx;
            sh      <= next_sh;
            wr      <= next_wr;
            rep     <= next_rep;
            ack_ok  <= next_ack_ok;
            sa      <= next_sa;
            dat     <= next_dat;
            to_cnt  <= next_to_cnt;
            scl_rel <= next_scl_rel;
            sda_rel <= next_sda_rel;
        end
    end

    assign smbus_clock_pin_o      = 1'b0;
    assign smbus_data_pin_o       = 1'b0;
    assign smbus_clock_pin_oe_n_o = scl_rel;
    assign smbus_data_pin_oe_n_o  = sda_rel;
    assign spd_cmd_ready_o        = (state == spd_pkg::SPD_IDLE);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [15:0] ctl;
    logic [15:0] next_ctl;
    logic [15:0] stat;
    logic [15:0] next_stat;
    logic [15:0] rdata;
    logic [15:0] next_rdata;
    logic        exp_pd;
    logic        next_exp_pd;
    logic        rd_stat;

    assign rd_stat = reg_rd_i && (reg_addr_i == spd_pkg::STAT_OFS);

    always_comb begin
        next_ctl    = ctl;
        next_stat   = stat;
        next_rdata  = rdata;
        next_exp_pd = exp_pd;
        if (reg_wr_i && reg_addr_i == spd_pkg::CTL_OFS) begin
            next_ctl = reg_wdata_i;
        end
        if (exp_cell_init_i) begin
            next_exp_pd = 1'b0;
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                spd_pkg::CTL_OFS:  next_rdata = ctl;
                spd_pkg::STAT_OFS: next_rdata = stat;
                default:           next_rdata = 16'h0000;
            endcase
        end
        if (rd_stat) begin
            next_stat[spd_pkg::STAT_VALID] = 1'b0;
        end
        if (accept) begin
            next_stat[spd_pkg::STAT_DONE] = 1'b0;
            next_stat[spd_pkg::STAT_ERR]  = 1'b0;
        end
        if (fin_ok) begin
            next_stat[spd_pkg::STAT_DONE] = 1'b1;
            if (!wr) begin
                next_stat[7:0] = sh;
                next_stat[spd_pkg::STAT_VALID] = 1'b1;
            end
        end
        if (fin_err) begin
            next_stat[spd_pkg::STAT_DONE] = 1'b1;
            next_stat[spd_pkg::STAT_ERR]  = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctl    <= spd_pkg::CTL_RST;
            stat   <= spd_pkg::STAT_RST;
            rdata  <= 16'h0000;
            exp_pd <= 1'b1;
        end else begin
            ctl    <= next_ctl;
            stat   <= next_stat;
            rdata  <= next_rdata;
            exp_pd <= next_exp_pd;
        end
    end

    assign reg_rdata_o   = rdata;
    assign exp_cell_pd_o = exp_pd;

    // ------------------------------------------------------------
    // stick channel power and clock generator enables
    // ------------------------------------------------------------
    for (genvar c = 0; c < 2; c++) begin : g_stick
        logic pd;
        logic next_pd;
        logic cken;
        logic next_cken;

        always_comb begin
            next_pd   = pd;
            next_cken = ctl[spd_pkg::CTL_CKEN_A + c]
                        && !ctl[spd_pkg::CTL_OFF_A + c];
            if (stick_cell_init_i) begin
                next_pd = 1'b0;
            end
            if (ctl[spd_pkg::CTL_OFF_A + c]) begin
                next_pd = 1'b1;
            end
        end

        always_ff @(posedge mclk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                pd   <= 1'b1;
                cken <= 1'b0;
            end else begin
                pd   <= next_pd;
                cken <= next_cken;
            end
        end

        assign stick_cell_pd_o[c]      = pd;
        assign clock_generator_en_o[c] = cken;
    end
endmodule : spd_smbus_master
`default_nettype wire

// ---- src/spd_pkg.sv ----
// constants for the spd eeprom smbus master
package spd_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] CTL_OFS  = 8'h02;
    localparam logic [7:0] STAT_OFS = 8'h0b;
    localparam logic [15:0] CTL_RST  = 16'h0000;
    localparam logic [15:0] STAT_RST = 16'h0000;
    // control fields: stick off bits and clock generator enables
    localparam int CTL_OFF_A   = 0;
    localparam int CTL_OFF_B   = 1;
    localparam int CTL_CKEN_A  = 2;
    localparam int CTL_CKEN_B  = 3;
    // status fields
    localparam int STAT_VALID = 15;
    localparam int STAT_DONE  = 14;
    localparam int STAT_ERR   = 13;
    // ------------------------------------------------------------
    // smbus timing
    // ------------------------------------------------------------
    localparam int SMB_DIV     = 16;
    localparam int PH_LAST     = SMB_DIV - 1;
    localparam int PH_SAMPLE   = SMB_DIV / 2 - 1;
    localparam int TIMEOUT_MS  = 25;
    localparam int CLK_KHZ     = 125000;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;
    // ------------------------------------------------------------
    // sequencer states, gray along start, byte, ack, stop
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SPD_IDLE  = 3'h0,
        SPD_START = 3'h1,
        SPD_BYTE  = 3'h3,
        SPD_ACK   = 3'h2,
        SPD_STOP  = 3'h6
    } spd_state_e;
endpackage : spd_pkg

// ---- sim/spd_smbus_master_monitor.sv ----
// port checker for the spd smbus master
`timescale 1ns/100ps
`default_nettype none
module spd_smbus_master_monitor #(
    parameter int TIMEOUT_CYC = 200
) (
    input wire logic        mclk_i,
    input wire logic        nrst_i,
    input wire logic        expansion_serial_clock_i,
    input wire logic        spd_cmd_valid_i,
    input wire logic        spd_cmd_ready_o,
    input wire logic        reg_wr_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic        exp_cell_init_i,
    input wire logic        stick_cell_init_i,
    input wire logic        exp_cell_pd_o,
    input wire logic [1:0]  stick_cell_pd_o,
    input wire logic [1:0]  clock_generator_en_o,
    input wire logic        smbus_clock_pin_i,
    input wire logic        smbus_clock_pin_oe_n_o,
    input wire logic        smbus_data_pin_oe_n_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    // ----------------------------------------
    // tick and stall counters
    // ----------------------------------------
    logic       ser_q;
    logic       scl_q;
    logic       seen;
    logic [4:0] tick_cnt;
    int         stall_cnt;
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ser_q <= 1'b0;
            scl_q <= 1'b1;
            seen <= 1'b0;
            tick_cnt <= 5'h00;
            stall_cnt <= 0;
        end else begin
            ser_q <= expansion_serial_clock_i;
            scl_q <= smbus_clock_pin_oe_n_o;
            if (scl_q && !smbus_clock_pin_oe_n_o)
                tick_cnt <= 5'h00;
            else if (expansion_serial_clock_i && !ser_q && tick_cnt != 5'h1f)
                tick_cnt <= tick_cnt + 5'h01;
            if (spd_cmd_ready_o)
                seen <= 1'b0;
            else if (scl_q && !smbus_clock_pin_oe_n_o)
                seen <= 1'b1;
            if (!spd_cmd_ready_o && smbus_clock_pin_oe_n_o && !smbus_clock_pin_i)
                stall_cnt <= stall_cnt + 1;
            else
                stall_cnt <= 0;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_scl_div;
        $fell(smbus_clock_pin_oe_n_o) && seen |-> tick_cnt == 5'h10;
    endproperty
    a_scl_div: assert property (p_scl_div)
        else $error("smbus clock period not sixteen ticks");
    property p_idle_release;
        spd_cmd_ready_o && $past(spd_cmd_ready_o)
            |-> smbus_clock_pin_oe_n_o && smbus_data_pin_oe_n_o;
    endproperty
    a_idle_release: assert property (p_idle_release)
        else $error("smbus line driven while idle");
    property p_reset_vals;
        $rose(nrst_i) |-> exp_cell_pd_o && stick_cell_pd_o == 2'b11
            && clock_generator_en_o == 2'b00 && reg_rdata_o == 16'h0000;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("outputs not at reset values");
    property p_off_gate;
        reg_wr_i && reg_addr_i == spd_pkg::CTL_OFS && reg_wdata_i[1]
            |-> ##2 !clock_generator_en_o[1] && stick_cell_pd_o[1];
    endproperty
    a_off_gate: assert property (p_off_gate)
        else $error("stick b not shut off");
    property p_stick_hold;
        stick_cell_pd_o[1] && !stick_cell_init_i |=> stick_cell_pd_o[1];
    endproperty
    a_stick_hold: assert property (p_stick_hold)
        else $error("stick cell left power down without init");
    property p_exp_hold;
        $fell(exp_cell_pd_o) |-> $past(exp_cell_init_i);
    endproperty
    a_exp_hold: assert property (p_exp_hold)
        else $error("expansion cell left power down without init");
    property p_busy;
        spd_cmd_valid_i && spd_cmd_ready_o |=> !spd_cmd_ready_o [*8];
    endproperty
    a_busy: assert property (p_busy)
        else $error("accepted command did not start");
    property p_to_late;
        !spd_cmd_ready_o |-> stall_cnt <= TIMEOUT_CYC + 4;
    endproperty
    a_to_late: assert property (p_to_late)
        else $error("stalled transfer not abandoned");
    property p_to_early;
        $rose(spd_cmd_ready_o) && stall_cnt != 0
            |-> stall_cnt >= TIMEOUT_CYC - 4;
    endproperty
    a_to_early: assert property (p_to_early)
        else $error("stalled transfer abandoned too early");
endmodule : spd_smbus_master_monitor

bind spd_smbus_master spd_smbus_master_monitor #(
    .TIMEOUT_CYC(TIMEOUT_CYC)
) i_spd_smbus_master_monitor (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .expansion_serial_clock_i(expansion_serial_clock_i),
    .spd_cmd_valid_i(spd_cmd_valid_i),
    .spd_cmd_ready_o(spd_cmd_ready_o),
    .reg_wr_i(reg_wr_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .exp_cell_init_i(exp_cell_init_i),
    .stick_cell_init_i(stick_cell_init_i),
    .exp_cell_pd_o(exp_cell_pd_o),
    .stick_cell_pd_o(stick_cell_pd_o),
    .clock_generator_en_o(clock_generator_en_o),
    .smbus_clock_pin_i(smbus_clock_pin_i),
    .smbus_clock_pin_oe_n_o(smbus_clock_pin_oe_n_o),
    .smbus_data_pin_oe_n_o(smbus_data_pin_oe_n_o)
);
`default_nettype wire

// ---- sim/spd_eeprom_model.sv ----
// behavioural smbus eeprom: byte write and random read
`timescale 1ns/100ps
`default_nettype none
module spd_eeprom_model #(
    parameter logic [6:0] DEV_ADDR = 7'h50
) (
    input  wire logic scl_i,
    input  wire logic sda_i,
    input  wire logic stretch_i,
    output logic      scl_low_o,
    output logic      sda_low_o
);
    logic [7:0] mem [256];
    logic [7:0] sh;
    logic [7:0] tx;
    logic [7:0] ptr;
    int         cnt;
    int         nbyte;
    logic       sel;
    logic       rd;
    assign scl_low_o = stretch_i;
    initial begin
        sda_low_o = 1'b0;
        sel = 1'b0;
        rd = 1'b0;
        ptr = 8'h00;
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i) + 8'h3c;
    end
    // start and stop conditions
    always @(negedge sda_i) if (scl_i) begin
        cnt = 0;
        nbyte = 0;
        rd = 1'b0;
        sel = 1'b1;
    end
    always @(posedge sda_i) if (scl_i) begin
        sel = 1'b0;
        sda_low_o = 1'b0;
    end
    // msb first, ack on ninth clock
    always @(posedge scl_i) if (sel) begin
        cnt++;
        if (cnt <= 8)
            sh = {sh[6:0], sda_i};
        else if (rd && sda_i)
            sel = 1'b0;
    end
    always @(negedge scl_i) if (sel) begin
        if (cnt == 9) begin
            cnt = 0;
            sda_low_o = 1'b0;
            if (rd) begin
                tx = mem[ptr];
                ptr = ptr + 8'h01;
                sda_low_o = ~tx[7];
            end
        end else if (rd) begin
            sda_low_o = (cnt < 8) ? ~tx[7-cnt] : 1'b0;
        end else if (cnt == 8) begin
            if (nbyte == 0) begin
                sel = (sh[7:1] == DEV_ADDR);
                rd = sh[0] & sel;
            end else if (nbyte == 1) begin
                ptr = sh;
            end else begin
                mem[ptr] = sh;
                ptr = ptr + 8'h01;
            end
            sda_low_o = sel;
            nbyte++;
        end
    end
endmodule : spd_eeprom_model
`default_nettype wire

// ---- sim/tb_spd_smbus_master.sv ----
// self-checking bench for the spd smbus master
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
    n_mismatch++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
    $time, got, exp); end end
module tb_spd_smbus_master;
    localparam int TO_CYC = 200;
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic        sclk = 1'b0;
    logic        cvalid = 1'b0;
    logic        cwrite = 1'b0;
    logic [7:0]  caddr = 8'h00;
    logic [15:0] cdata = 16'h0000;
    logic        rwr = 1'b0;
    logic        rrd = 1'b0;
    logic [7:0]  raddr = 8'h00;
    logic [15:0] rwdata = 16'h0000;
    logic        einit = 1'b0;
    logic        sinit = 1'b0;
    logic        stretch = 1'b0;
    logic        cready, epd, scl_oe_n, sda_oe_n, m_scl_low, m_sda_low;
    logic [1:0]  stpd, cken;
    logic [15:0] rdata, v;
    wire logic   scl;
    wire logic   sda;
    int          n_mismatch = 0;
    int          checked = 0;
    // wired-and with pull-up
    assign scl = scl_oe_n & ~m_scl_low;
    assign sda = sda_oe_n & ~m_sda_low;
    always #4 mclk = ~mclk;
    initial #5 forever #32 sclk = ~sclk; // scaled
    spd_smbus_master #(.TIMEOUT_CYC(TO_CYC)) i_spd_smbus_master (
        .mclk_i(mclk), .nrst_i(nrst), .expansion_serial_clock_i(sclk),
        .spd_cmd_valid_i(cvalid), .spd_cmd_write_i(cwrite),
        .slave_address_field_i(caddr), .data_field_i(cdata),
        .spd_cmd_ready_o(cready), .reg_wr_i(rwr), .reg_rd_i(rrd),
        .reg_addr_i(raddr), .reg_wdata_i(rwdata), .reg_rdata_o(rdata),
        .exp_cell_init_i(einit), .stick_cell_init_i(sinit),
        .exp_cell_pd_o(epd), .stick_cell_pd_o(stpd),
        .clock_generator_en_o(cken), .smbus_clock_pin_i(scl),
        .smbus_clock_pin_o(), .smbus_clock_pin_oe_n_o(scl_oe_n),
        .smbus_data_pin_i(sda), .smbus_data_pin_o(),
        .smbus_data_pin_oe_n_o(sda_oe_n));
    spd_eeprom_model #(.DEV_ADDR(7'h50)) i_spd_eeprom_model (
        .scl_i(scl), .sda_i(sda), .stretch_i(stretch),
        .scl_low_o(m_scl_low), .sda_low_o(m_sda_low));
    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk) #1;
        rwr = 1'b1;
        raddr = a;
        rwdata = d;
        @(posedge mclk) #1;
        rwr = 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
        @(posedge mclk) #1;
        rrd = 1'b1;
        raddr = a;
        @(posedge mclk) #1;
        rrd = 1'b0;
        d = rdata;
    endtask : reg_read
    task automatic spd_cmd(input logic w, input logic [7:0] sa,
                           input logic [15:0] d);
        int n;
        @(posedge mclk) #1;
        cvalid = 1'b1;
        cwrite = w;
        caddr = sa;
        cdata = d;
        @(posedge mclk) #1;
        cvalid = 1'b0;
        v = 16'h0000;
        n = 0;
        while (v[14] !== 1'b1 && n < 10000) begin
            reg_read(spd_pkg::STAT_OFS, v);
            n++;
        end
        `CHK(cready, 1'b1)
    endtask : spd_cmd
    task automatic print_verdict;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict
    initial begin
        #(8 * 60000);
        n_mismatch++;
        print_verdict;
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge mclk);
        #1 nrst = 1'b1;
        `CHK(epd, 1'b1)
        `CHK(stpd, 2'b11)
        `CHK(cken, 2'b00)
        reg_read(spd_pkg::CTL_OFS, v);
        `CHK(v, spd_pkg::CTL_RST)
        reg_write(spd_pkg::STAT_OFS, 16'hffff);
        reg_read(spd_pkg::STAT_OFS, v);
        `CHK(v, spd_pkg::STAT_RST)
        reg_read(8'h40, v);
        `CHK(v, 16'h0000)
        reg_write(spd_pkg::CTL_OFS, 16'h000c);
        reg_read(spd_pkg::CTL_OFS, v);
        `CHK(v, 16'h000c)
        `CHK(cken, 2'b11)
        @(posedge mclk) #1;
        sinit = 1'b1;
        einit = 1'b1;
        @(posedge mclk) #1;
        sinit = 1'b0;
        einit = 1'b0;
        @(posedge mclk) #1;
        `CHK({epd, stpd}, 3'b000)
        reg_write(spd_pkg::CTL_OFS, 16'h000e);
        @(posedge mclk) #1;
        `CHK({stpd, cken}, 4'b1001)
        spd_cmd(1'b1, 8'ha0, 16'ha510);
        `CHK(v[15:13], 3'b010)
        `CHK(i_spd_eeprom_model.mem[8'h10], 8'ha5)
        spd_cmd(1'b0, 8'ha0, 16'h0010);
        `CHK(v, 16'hc0a5)
        reg_read(spd_pkg::STAT_OFS, v);
        `CHK(v[15], 1'b0)
        spd_cmd(1'b1, 8'ha2, 16'h0000);
        `CHK(v[14:13], 2'b11)
        spd_cmd(1'b0, 8'ha0, 16'h00ff);
        `CHK(v[15:13], 3'b110)
        `CHK(v[7:0], 8'h3b)
        stretch = 1'b1;
        spd_cmd(1'b0, 8'ha0, 16'h0000);
        stretch = 1'b0;
        `CHK(v[14:13], 2'b11)
        nrst = 1'b0;
        repeat (2) @(posedge mclk);
        #1 nrst = 1'b1;
        `CHK({epd, stpd, cken}, 5'b11100)
        reg_read(spd_pkg::CTL_OFS, v);
        `CHK(v, spd_pkg::CTL_RST)
        print_verdict;
    end
endmodule : tb_spd_smbus_master
`default_nettype wire
